// *** rtl/boot_config_bank.sv ***
/*
 * Fieldbus select and boot configuration object bank of a motor controller.
 * Holds the boot encoder position, pulse input selector, boot delay and fieldbus bitmaps.
 * Assumes the fieldbus master drives one request per cycle, synchronous to i_clk.
 */
`default_nettype none

module boot_config_bank #(
   parameter int CYCLES_PER_MS = boot_config_pkg::CYCLES_PER_MS
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_resetn,
   input  wire boot_config_pkg::obj_req_t i_req,
   input  wire logic                      i_abs_encoder_fitted,
   input  wire logic [31:0]               i_encoder_position,
   output var  logic                      o_ack,
   output var  logic                      o_err,
   output var  logic [31:0]               o_rdata,
   output var  logic                      o_pulse_mode_ccw,
   output var  logic                      o_ready,
   output var  logic [31:0]               o_fieldbus_active
);

   boot_config_pkg::bank_state_t st_r;
   boot_config_pkg::bank_state_t st_nxt;
   logic                         timer_ready;
   logic                         req_any;
   logic [31:0]                  ctrl_written;

   // ==========================================================================
   // boot delay timer
   // ==========================================================================
   boot_delay_timer #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_timer (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_delay_ms (st_r.boot_delay_r),
      .o_ready    (timer_ready)
   );

   assign req_any = i_req.wr | i_req.rd;
   // fixed buses keep their state; only switchable bits follow the write
   assign ctrl_written = (st_r.fb_ctrl_r & ~boot_config_pkg::FB_SW_MASK)
                       | (i_req.wdata & boot_config_pkg::FB_SW_MASK);

   // ==========================================================================
   // next state
   // ==========================================================================
   always_comb begin
      st_nxt       = st_r;
      st_nxt.ack_r = req_any;
      st_nxt.err_r = 1'b0;
      st_nxt.rdata_r = 32'h00000000;

      // the capture waits for the first edge after release, never the reset itself
      if (!st_r.captured_r) begin
         st_nxt.captured_r = 1'b1;
         st_nxt.boot_pos_r = i_abs_encoder_fitted ? i_encoder_position
                                                  : boot_config_pkg::BOOT_POS_RST;
      end

      st_nxt.ready_r     = timer_ready;
      // unnamed bits set in the availability preset stay active; masking them would break the status preset
      st_nxt.fb_active_r = st_r.fb_ctrl_r & boot_config_pkg::FB_AVAIL;

      if (i_req.wr) begin
         unique case (i_req.index)
            boot_config_pkg::IDX_PULSE_MODE: begin
               if (i_req.sub != boot_config_pkg::SUB_MAIN) begin
                  st_nxt.err_r = 1'b1;
               end else if (i_req.wdata == boot_config_pkg::PULSE_STEP_DIR ||
                            i_req.wdata == boot_config_pkg::PULSE_CW_CCW) begin
                  st_nxt.pulse_mode_r = i_req.wdata[0];
               end else begin
                  // only the two documented modes are taken
                  st_nxt.err_r = 1'b1;
               end
            end
            boot_config_pkg::IDX_BOOT_DELAY: begin
               if (i_req.sub == boot_config_pkg::SUB_MAIN) begin
                  st_nxt.boot_delay_r = i_req.wdata;
               end else begin
                  st_nxt.err_r = 1'b1;
               end
            end
            boot_config_pkg::IDX_FB_CTRL: begin
               if (i_req.sub == boot_config_pkg::SUB_MAIN) begin
                  st_nxt.fb_ctrl_r = ctrl_written;
               end else begin
                  st_nxt.err_r = 1'b1;
               end
            end
            default: begin
               // read-only or unknown objects refuse writes
               st_nxt.err_r = 1'b1;
            end
         endcase
      end else if (i_req.rd) begin
         unique case (i_req.index)
            boot_config_pkg::IDX_BOOT_POS: begin
               st_nxt.err_r   = (i_req.sub != boot_config_pkg::SUB_MAIN);
               st_nxt.rdata_r = st_r.boot_pos_r;
            end
            boot_config_pkg::IDX_PULSE_MODE: begin
               st_nxt.err_r   = (i_req.sub != boot_config_pkg::SUB_MAIN);
               st_nxt.rdata_r = {31'h00000000, st_r.pulse_mode_r};
            end
            boot_config_pkg::IDX_BOOT_DELAY: begin
               st_nxt.err_r   = (i_req.sub != boot_config_pkg::SUB_MAIN);
               st_nxt.rdata_r = st_r.boot_delay_r;
            end
            boot_config_pkg::IDX_FB_AVAIL: begin
               st_nxt.err_r   = (i_req.sub != boot_config_pkg::SUB_MAIN);
               st_nxt.rdata_r = boot_config_pkg::FB_AVAIL;
            end
            boot_config_pkg::IDX_FB_CTRL: begin
               st_nxt.err_r   = (i_req.sub != boot_config_pkg::SUB_MAIN);
               st_nxt.rdata_r = st_r.fb_ctrl_r;
            end
            boot_config_pkg::IDX_FB_STATUS: begin
               unique case (i_req.sub)
                  boot_config_pkg::SUB_MAIN:    st_nxt.rdata_r = boot_config_pkg::STATUS_ENTRIES;
                  boot_config_pkg::SUB_SW_MASK: st_nxt.rdata_r = boot_config_pkg::FB_SW_MASK;
                  boot_config_pkg::SUB_ACTIVE:  st_nxt.rdata_r = st_r.fb_active_r;
                  default:                      st_nxt.err_r   = 1'b1;
               endcase
            end
            default: begin
               st_nxt.err_r = 1'b1;
            end
         endcase
      end
      if (st_nxt.err_r) begin
         st_nxt.rdata_r = 32'h00000000;
      end
   end

   // ==========================================================================
   // state register
   // ==========================================================================
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r.captured_r   <= 1'b0;
         st_r.boot_pos_r   <= boot_config_pkg::BOOT_POS_RST;
         st_r.pulse_mode_r <= boot_config_pkg::PULSE_MODE_RST;
         st_r.boot_delay_r <= boot_config_pkg::BOOT_DELAY_RST;
         st_r.fb_ctrl_r    <= boot_config_pkg::FB_CTRL_RST;
         st_r.fb_active_r  <= boot_config_pkg::FB_ACTIVE_RST;
         st_r.ready_r      <= 1'b0;
         st_r.ack_r        <= 1'b0;
         st_r.err_r        <= 1'b0;
         st_r.rdata_r      <= 32'h00000000;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_ack             = st_r.ack_r;
   assign o_err             = st_r.err_r;
   assign o_rdata           = st_r.rdata_r;
   assign o_pulse_mode_ccw  = st_r.pulse_mode_r;
   assign o_ready           = st_r.ready_r;
   assign o_fieldbus_active = st_r.fb_active_r;

   // ==========================================================================
   // assertions
   // ==========================================================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   property p_boot_zero;
      (!st_r.captured_r && !i_abs_encoder_fitted) |=> (st_r.boot_pos_r == 32'h00000000) [*3];
   endproperty
   a_boot_zero: assert property (p_boot_zero) else $error("boot position not zero without encoder");

   property p_boot_hold;
      (st_r.captured_r && !i_req.wr) |=> $stable(st_r.boot_pos_r) && st_r.captured_r;
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("boot position changed after capture");

   property p_pulse_mode;
      (i_req.wr && i_req.index == boot_config_pkg::IDX_PULSE_MODE && i_req.sub == boot_config_pkg::SUB_MAIN
       && i_req.wdata[31:1] == 31'h00000000) |=> o_pulse_mode_ccw == $past(i_req.wdata[0]) && !o_err;
   endproperty
   a_pulse_mode: assert property (p_pulse_mode) else $error("pulse mode not taken");

   property p_ready;
      $rose(o_ready) |-> u_timer.st_r.ms_r >= st_r.boot_delay_r;
   endproperty
   a_ready: assert property (p_ready) else $error("ready raised before boot delay");

   property p_avail_read;
      (i_req.rd && !i_req.wr && i_req.index == boot_config_pkg::IDX_FB_AVAIL && i_req.sub == boot_config_pkg::SUB_MAIN)
         |=> o_ack && !o_err && o_rdata == 32'h0019000f;
   endproperty
   a_avail_read: assert property (p_avail_read) else $error("availability map read wrong");

   property p_fixed_kept;
      (i_req.wr && i_req.index == boot_config_pkg::IDX_FB_CTRL)
         |=> (st_r.fb_ctrl_r & ~32'h0000000e) == ($past(st_r.fb_ctrl_r) & ~32'h0000000e);
   endproperty
   a_fixed_kept: assert property (p_fixed_kept) else $error("fixed bus changed by control write");

   property p_switch_taken;
      (i_req.wr && i_req.index == boot_config_pkg::IDX_FB_CTRL && i_req.sub == boot_config_pkg::SUB_MAIN)
         |=> ##1 (o_fieldbus_active & 32'h0000000e) == ($past(i_req.wdata, 2) & 32'h0000000e);
   endproperty
   a_switch_taken: assert property (p_switch_taken) else $error("switchable bus not applied");

   property p_active_legal;
      (o_fieldbus_active & ~32'h0019000f) == 32'h00000000
         && ((o_fieldbus_active ^ 32'h0019000f) & ~32'h0000000e) == 32'h00000000;
   endproperty
   a_active_legal: assert property (p_active_legal) else $error("unavailable or fixed bus wrong in status");

   property p_mask_read;
      (i_req.rd && !i_req.wr && i_req.index == boot_config_pkg::IDX_FB_STATUS && i_req.sub == boot_config_pkg::SUB_SW_MASK)
         |=> o_ack && o_rdata == 32'h0000000e;
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("switchable mask read wrong");

   property p_ro_refused;
      (i_req.wr && (i_req.index == boot_config_pkg::IDX_FB_AVAIL || i_req.index == boot_config_pkg::IDX_FB_STATUS
                    || i_req.index == boot_config_pkg::IDX_BOOT_POS)) |=> o_ack && o_err;
   endproperty
   a_ro_refused: assert property (p_ro_refused) else $error("write to read-only object accepted");

   property p_active_status;
      (i_req.rd && !i_req.wr && i_req.index == boot_config_pkg::IDX_FB_STATUS && i_req.sub == boot_config_pkg::SUB_ACTIVE)
         |=> o_rdata == $past(st_r.fb_active_r);
   endproperty
   a_active_status: assert property (p_active_status) else $error("enabled status read wrong");

   c_ctrl_write: cover property (i_req.wr && i_req.index == boot_config_pkg::IDX_FB_CTRL ##2 o_fieldbus_active[1] == 1'b0);
   c_ready:      cover property ($rose(o_ready));
   c_ccw_mode:   cover property ($rose(o_pulse_mode_ccw));
   c_err:        cover property (o_ack && o_err);

endmodule : boot_config_bank

`default_nettype wire

// *** common/boot_config_pkg.sv ***
/*
 * Constants, object map and state carriers for the fieldbus select and boot config bank.
 * Assumes a single 100 MHz controller clock and an object access port (index, subindex) per request.
 */
`default_nettype none

package boot_config_pkg;

   // ==========================================================================
   // timing
   // ==========================================================================
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          MS_IN_NS      = 1000000;
   localparam int          CYCLES_PER_MS = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================================
   // object indices and subindices
   // ==========================================================================
   localparam logic [15:0] IDX_BOOT_POS    = 16'h205a;
   localparam logic [15:0] IDX_PULSE_MODE  = 16'h205b;
   localparam logic [15:0] IDX_BOOT_DELAY  = 16'h2084;
   localparam logic [15:0] IDX_FB_AVAIL    = 16'h2101;
   localparam logic [15:0] IDX_FB_CTRL     = 16'h2102;
   localparam logic [15:0] IDX_FB_STATUS   = 16'h2103;
   localparam logic [7:0]  SUB_MAIN        = 8'h00;
   localparam logic [7:0]  SUB_SW_MASK     = 8'h01;
   localparam logic [7:0]  SUB_ACTIVE      = 8'h02;
   localparam logic [31:0] STATUS_ENTRIES  = 32'h00000002;

   // ==========================================================================
   // reset values
   // ==========================================================================
   localparam logic [31:0] BOOT_POS_RST    = 32'h00000000;
   localparam logic        PULSE_MODE_RST  = 1'h0;
   localparam logic [31:0] BOOT_DELAY_RST  = 32'h00000000;
   localparam logic [31:0] FB_AVAIL        = 32'h0019000f;
   localparam logic [31:0] FB_CTRL_RST     = 32'h0019000f;
   localparam logic [31:0] FB_SW_MASK      = 32'h0000000e;
   localparam logic [31:0] FB_ACTIVE_RST   = 32'h0019000f;

   // ==========================================================================
   // bitmap layout: low half interfaces, high half protocols
   // ==========================================================================
   localparam int          IF_FIELD_LSB    = 0;
   localparam int          IF_FIELD_MSB    = 15;
   localparam int          PROTO_FIELD_LSB = 16;
   localparam int          PROTO_FIELD_MSB = 31;
   localparam int          USB_BIT                          = 0;
   localparam int          RS485_BIT                        = 1;
   localparam int          RS232_BIT                        = 2;
   localparam int          CAN_BIT                          = 3;
   localparam int          ETHERNET_PORT_BIT                = 4;
   localparam int          INDUSTRIAL_ETHERNET_FIELDBUS_BIT = 5;
   localparam int          SPI_BIT                          = 6;
   localparam int          SERIAL_REGISTER_PROTOCOL_BIT     = 16;
   localparam int          TCP_REGISTER_PROTOCOL_BIT        = 17;
   localparam int          INDUSTRIAL_IP_PROTOCOL_BIT       = 18;
   localparam logic [31:0] FB_ASSIGNED_BITS = 32'h0007007f;

   // pulse input selector values
   localparam logic [31:0] PULSE_STEP_DIR  = 32'h00000000;
   localparam logic [31:0] PULSE_CW_CCW    = 32'h00000001;

   // ==========================================================================
   // carriers
   // ==========================================================================
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] wdata;
   } obj_req_t;

   typedef struct packed {
      logic [31:0] tick_r;
      logic [31:0] ms_r;
      logic        ready_r;
   } timer_state_t;

   typedef struct packed {
      logic        captured_r;
      logic [31:0] boot_pos_r;
      logic        pulse_mode_r;
      logic [31:0] boot_delay_r;
      logic [31:0] fb_ctrl_r;
      logic [31:0] fb_active_r;
      logic        ready_r;
      logic        ack_r;
      logic        err_r;
      logic [31:0] rdata_r;
   } bank_state_t;

endpackage : boot_config_pkg

`default_nettype wire

// *** rtl/boot_delay_timer.sv ***
/*
 * Millisecond boot delay timer: counts whole milliseconds since reset release and
 * raises a sticky ready once the elapsed count reaches the live delay value.
 * Assumes the delay input is stable or only grows while the timer is still waiting.
 */
`default_nettype none

module boot_delay_timer #(
   parameter int CYCLES_PER_MS = boot_config_pkg::CYCLES_PER_MS
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [31:0] i_delay_ms,
   output var  logic        o_ready
);

   localparam logic [31:0] TICK_LAST = 32'(CYCLES_PER_MS - 1);

   boot_config_pkg::timer_state_t st_r;
   boot_config_pkg::timer_state_t st_nxt;

   // ==========================================================================
   // next state
   // ==========================================================================
   always_comb begin
      st_nxt = st_r;
      if (!st_r.ready_r) begin
         if (st_r.ms_r >= i_delay_ms) begin
            st_nxt.ready_r = 1'b1;
         end else if (st_r.tick_r == TICK_LAST) begin
            st_nxt.tick_r = 32'h00000000;
            st_nxt.ms_r   = st_r.ms_r + 32'h00000001;
         end else begin
            st_nxt.tick_r = st_r.tick_r + 32'h00000001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_ready = st_r.ready_r;

endmodule : boot_delay_timer

`default_nettype wire

// *** dv/fieldbus_master_model.sv ***
/*
 * Fieldbus master model: issues one object read or write at a time and samples the answer.
 * Assumes the bank takes a request at a rising edge and answers on the following one.
 */
`default_nettype none

module fieldbus_master_model (
   input  wire logic                      i_clk,
   output var  boot_config_pkg::obj_req_t o_req,
   input  wire logic                      i_ack,
   input  wire logic                      i_err,
   input  wire logic [31:0]               i_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial o_req = '0;

   // ==================
   // one transfer
   // ==================
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, output logic ok, output logic err,
                       output logic [31:0] rdat);
      ok = 1'b0;
      err = 1'b1;
      rdat = 32'h0;
      @(posedge i_clk);
      o_req <= '{wr: wr, rd: !wr, index: idx, sub: sub, wdata: wd};
      @(posedge i_clk);
      // released fields carry the inverse so a stale value never looks live
      o_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, sub: ~sub, wdata: ~wd};
      @(posedge i_clk);
      if (i_ack === 1'b1) begin
         ok = 1'b1;
         err = i_err;
         rdat = i_rdata;
      end
   endtask : xfer

endmodule : fieldbus_master_model

`default_nettype wire

// *** dv/fieldbus_select_boot_config_bank_bench.sv ***
/*
 * Self-checking bench for the boot config bank: object table, reset values, bit switching.
 * Assumes the bank answers every request exactly one cycle after the taking edge.
 */
`default_nettype none

module fieldbus_select_boot_config_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic        wr;
      logic [15:0] idx;
      logic [7:0]  sub;
      logic [31:0] wd;
      logic        err;
      logic [31:0] rd;
   } row_t;

   // ==================
   // object table
   // ==================
   localparam row_t ROWS [26] = '{
      '{1'h0, 16'h205a, 8'h00, 32'h0, 1'h0, 32'hfedcba98},
      '{1'h1, 16'h205a, 8'h00, 32'h1, 1'h1, 32'h0},
      '{1'h0, 16'h205a, 8'h00, 32'h0, 1'h0, 32'hfedcba98},
      '{1'h0, 16'h205b, 8'h00, 32'h0, 1'h0, 32'h0},
      '{1'h1, 16'h205b, 8'h00, 32'h1, 1'h0, 32'h0},
      '{1'h0, 16'h205b, 8'h00, 32'h0, 1'h0, 32'h1},
      '{1'h1, 16'h205b, 8'h00, 32'h2, 1'h1, 32'h0},
      '{1'h0, 16'h205b, 8'h00, 32'h0, 1'h0, 32'h1},
      '{1'h0, 16'h2084, 8'h00, 32'h0, 1'h0, 32'h0},
      '{1'h1, 16'h2084, 8'h00, 32'h7, 1'h0, 32'h0},
      '{1'h0, 16'h2084, 8'h00, 32'h0, 1'h0, 32'h7},
      '{1'h0, 16'h2101, 8'h00, 32'h0, 1'h0, 32'h0019000f},
      '{1'h1, 16'h2101, 8'h00, 32'h0, 1'h1, 32'h0},
      '{1'h0, 16'h2102, 8'h00, 32'h0, 1'h0, 32'h0019000f},
      '{1'h0, 16'h2103, 8'h00, 32'h0, 1'h0, 32'h2},
      '{1'h0, 16'h2103, 8'h01, 32'h0, 1'h0, 32'he},
      '{1'h0, 16'h2103, 8'h02, 32'h0, 1'h0, 32'h0019000f},
      '{1'h1, 16'h2103, 8'h02, 32'h0, 1'h1, 32'h0},
      '{1'h1, 16'h2102, 8'h00, 32'h0, 1'h0, 32'h0},
      '{1'h0, 16'h2102, 8'h00, 32'h0, 1'h0, 32'h00190001},
      '{1'h0, 16'h2103, 8'h02, 32'h0, 1'h0, 32'h00190001},
      '{1'h1, 16'h2102, 8'h00, 32'hffffffff, 1'h0, 32'h0},
      '{1'h0, 16'h2102, 8'h00, 32'h0, 1'h0, 32'h0019000f},
      '{1'h0, 16'h2103, 8'h03, 32'h0, 1'h1, 32'h0},
      '{1'h0, 16'h2200, 8'h00, 32'h0, 1'h1, 32'h0},
      '{1'h1, 16'h2102, 8'h01, 32'h0, 1'h1, 32'h0}
   };

   logic                      clk      = 1'b0;
   logic                      resetn   = 1'b0;
   logic                      fitted   = 1'b1;
   logic [31:0]               position = 32'hfedcba98;
   boot_config_pkg::obj_req_t req;
   logic                      ack;
   logic                      err;
   logic [31:0]               rdata;
   logic                      ccw;
   logic                      ready;
   logic [31:0]               active;
   logic [31:0]               exp_map;
   int                        failures   = 0;
   int                        n_compared = 0;

   always #(boot_config_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

   boot_config_bank #(.CYCLES_PER_MS(4)) boot_config_bank_inst (
      .i_clk(clk), .i_resetn(resetn), .i_req(req), .i_abs_encoder_fitted(fitted),
      .i_encoder_position(position), .o_ack(ack), .o_err(err), .o_rdata(rdata),
      .o_pulse_mode_ccw(ccw), .o_ready(ready), .o_fieldbus_active(active));

   fieldbus_master_model fieldbus_master_model_inst (
      .i_clk(clk), .o_req(req), .i_ack(ack), .i_err(err), .i_rdata(rdata));

   // ==================
   // checking
   // ==================
   task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp32

   task automatic cmp1(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : cmp1

   task automatic acc(input row_t r);
      logic        ok;
      logic        e;
      logic [31:0] d;
      string       nm;
      nm = $sformatf("obj %h:%h", r.idx, r.sub);
      fieldbus_master_model_inst.xfer(r.wr, r.idx, r.sub, r.wd, ok, e, d);
      cmp1({nm, " ack"}, 1'b1, ok);
      cmp1({nm, " err"}, r.err, e);
      cmp32({nm, " rdata"}, r.rd, d);
   endtask : acc

   task automatic rst(input logic fit, input logic [31:0] p);
      @(posedge clk);
      resetn <= 1'b0;
      fitted <= fit;
      position <= p;
      repeat (12) @(posedge clk);
      #1;
      cmp1("ready in reset", 1'b0, ready);
      cmp1("ccw in reset", 1'b0, ccw);
      cmp1("ack in reset", 1'b0, ack);
      cmp32("active in reset", 32'h0019000f, active);
      @(posedge clk);
      resetn <= 1'b1;
      // delay presets to zero, so readiness follows within three cycles
      repeat (3) @(posedge clk);
      #1;
      cmp1("ready", 1'b1, ready);
   endtask : rst

   task automatic print_verdict;
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   // ==================
   // sequence
   // ==================
   initial begin
      rst(1'b1, 32'hfedcba98);
      foreach (ROWS[k]) acc(ROWS[k]);
      cmp1("ccw", 1'b1, ccw);
      cmp1("ready sticky", 1'b1, ready);
      cmp32("active", 32'h0019000f, active);
      for (int b = 1; b <= 3; b++) begin
         exp_map = 32'h0019000f & ~(32'h1 << b);
         acc(row_t'{1'h1, 16'h2102, 8'h00, exp_map, 1'h0, 32'h0});
         @(posedge clk);
         #1;
         cmp32("active map", exp_map, active);
      end
      acc(row_t'{1'h1, 16'h205b, 8'h00, 32'h0, 1'h0, 32'h0});
      #1;
      cmp1("ccw", 1'b0, ccw);
      // power cycle without an encoder: boot value and stored objects go back to presets
      rst(1'b0, 32'h12345678);
      acc(row_t'{1'h0, 16'h205a, 8'h00, 32'h0, 1'h0, 32'h0});
      acc(row_t'{1'h0, 16'h2102, 8'h00, 32'h0, 1'h0, 32'h0019000f});
      acc(row_t'{1'h0, 16'h2084, 8'h00, 32'h0, 1'h0, 32'h0});
      acc(row_t'{1'h0, 16'h2103, 8'h02, 32'h0, 1'h0, 32'h0019000f});
      print_verdict();
   end

   initial begin
      #(boot_config_pkg::CLK_PERIOD_NS * 3000);
      failures++;
      print_verdict();
   end

endmodule : fieldbus_select_boot_config_bank_bench

`default_nettype wire
